// File: hdl/ccm_defs.svh
// Operation
// - reset invalidates all entries, cache stays disabled
// - reads return same data, cache on or off
// - registers reached over the peripheral register port
// - status bit shows enable; host checks it first
// - writing enable bit one turns caching on
// - host invalidates entries when memory contents change
// - line invalidate clears valid, repoints replacement counter
// - host disables, confirms, writes line, re-enables
// - invalidate-everything bit clears every entry
// - 32-bit monitor counts cycles, data or instruction hits
// - host sets monitor mode before enabling it
// - monitor counts only after run bit set
// - monitor clear bit zeroes the counter
// - monitor status register returns current count
`ifndef CCM_DEFS_SVH
`define CCM_DEFS_SVH

`define CCM_ADDR_W 8
`define CCM_DATA_W 32

`define CCM_OFF_CTRL 8'h00
`define CCM_OFF_SR 8'h04
`define CCM_OFF_MAINT0 8'h08
`define CCM_OFF_MAINT1 8'h0c
`define CCM_OFF_MCFG 8'h10
`define CCM_OFF_MEN 8'h14
`define CCM_OFF_MCTRL 8'h18
`define CCM_OFF_MSR 8'h1c

`define CCM_BIT_EN 0
`define CCM_BIT_ON 0
`define CCM_BIT_INVALIDATE_EVERYTHING_BIT 0
`define CCM_BIT_MRUN 0
`define CCM_BIT_MCLR 0
`define CCM_LINE_IDX_LSB 4
`define CCM_LINE_WAY_LSB 28

`define CCM_MODE_W 2
`define CCM_MODE_CYCLE 2'h0
`define CCM_MODE_DHIT 2'h1
`define CCM_MODE_IHIT 2'h2

`define CCM_SETS 16
`define CCM_WAYS 4

`endif

// File: hdl/ccm_pkg.sv
package ccm_pkg;
  typedef enum logic [1:0] {DEV_IDLE, DEV_HIT, DEV_FILL, DEV_ANSWER} ccm_dev_state_t;
  typedef enum logic [2:0] {OP_ENABLE, OP_DISABLE, OP_INV_LINE, OP_INV_ALL, OP_MON_START, OP_MON_CLEAR,
    OP_MON_READ} ccm_op_t;
  typedef enum logic [3:0] {HS_IDLE, HS_RD_SR, HS_WAIT_SR, HS_WR_DIS, HS_WR_EN, HS_WR_LINE, HS_WR_INVALIDATE_EVERYTHING_BIT,
    HS_WR_MCFG, HS_WR_MEN, HS_WR_MCLR, HS_RD_MSR, HS_WAIT_MSR, HS_WAIT_WR, HS_DONE} ccm_host_state_t;
endpackage : ccm_pkg

// File: hdl/ccm_reg_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccm_defs.svh"
interface ccm_reg_if;
  logic reg_wr;
  logic reg_rd;
  logic [`CCM_ADDR_W-1:0] reg_addr;
  logic [`CCM_DATA_W-1:0] reg_wdata;
  logic reg_ack;
  logic [`CCM_DATA_W-1:0] reg_rdata;
  modport host (output reg_wr, reg_rd, reg_addr, reg_wdata, input reg_ack, reg_rdata);
  modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata, output reg_ack, reg_rdata);
endinterface : ccm_reg_if
`default_nettype wire

// File: hdl/ccm_cache.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccm_defs.svh"
module ccm_cache #(
  parameter int SETS = `CCM_SETS,
  parameter int WAYS = `CCM_WAYS,
  parameter logic [`CCM_MODE_W-1:0] MODE_CYCLE = `CCM_MODE_CYCLE,
  parameter logic [`CCM_MODE_W-1:0] MODE_DHIT = `CCM_MODE_DHIT,
  parameter logic [`CCM_MODE_W-1:0] MODE_IHIT = `CCM_MODE_IHIT
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  ccm_reg_if.dev bus,
  input wire logic cpu_req_i,
  input wire logic [31:0] cpu_addr_i,
  input wire logic cpu_instr_i,
  output logic cpu_ready_o,
  output logic cpu_ack_o,
  output logic [31:0] cpu_rdata_o,
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i
);
  // geometry and mode codes are the parameters above
  localparam int IDX_W = (SETS > 1) ? $clog2(SETS) : 1;
  localparam int WAY_W = (WAYS > 1) ? $clog2(WAYS) : 1;
  localparam int TAG_W = 32 - IDX_W;

  function automatic logic [IDX_W-1:0] idx_of(input logic [31:0] a);
    idx_of = a[IDX_W-1:0];
  endfunction : idx_of

  function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
    tag_of = a[31:IDX_W];
  endfunction : tag_of

  function automatic logic reg_hit(input logic [`CCM_ADDR_W-1:0] a, input logic [`CCM_ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  ccm_pkg::ccm_dev_state_t state_q;
  logic en_q;
  logic on_q;
  logic [`CCM_MODE_W-1:0] mode_q;
  logic mrun_q;
  logic [31:0] count_q;
  logic [SETS-1:0][WAYS-1:0] valid_q;
  logic [SETS-1:0][WAY_W-1:0] repl_q;
  logic [TAG_W-1:0] tag_mem [SETS][WAYS];
  logic [31:0] data_mem [SETS][WAYS];
  logic [31:0] addr_q;
  logic instr_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic [`CCM_DATA_W-1:0] reg_rdata_q;
  logic reg_ack_q;

  logic wr_ctrl;
  logic wr_maint0;
  logic wr_maint1;
  logic wr_mcfg;
  logic wr_men;
  logic wr_mctrl;
  logic inv_all;
  logic [IDX_W-1:0] line_idx;
  logic [WAY_W-1:0] line_way;
  logic take;
  logic hit;
  logic [WAY_W-1:0] hit_way;
  logic dhit_ev;
  logic ihit_ev;
  logic fill_done;
  logic [IDX_W-1:0] fill_idx;
  logic [WAY_W-1:0] fill_way;

  // register write decode
  assign wr_ctrl = bus.reg_wr && reg_hit(bus.reg_addr, `CCM_OFF_CTRL);
  assign wr_maint0 = bus.reg_wr && reg_hit(bus.reg_addr, `CCM_OFF_MAINT0);
  assign wr_maint1 = bus.reg_wr && reg_hit(bus.reg_addr, `CCM_OFF_MAINT1);
  assign wr_mcfg = bus.reg_wr && reg_hit(bus.reg_addr, `CCM_OFF_MCFG);
  assign wr_men = bus.reg_wr && reg_hit(bus.reg_addr, `CCM_OFF_MEN);
  assign wr_mctrl = bus.reg_wr && reg_hit(bus.reg_addr, `CCM_OFF_MCTRL);
  assign inv_all = wr_maint0 && bus.reg_wdata[`CCM_BIT_INVALIDATE_EVERYTHING_BIT];
  assign line_idx = bus.reg_wdata[`CCM_LINE_IDX_LSB +: IDX_W];
  assign line_way = bus.reg_wdata[`CCM_LINE_WAY_LSB +: WAY_W];

  // lookup of the incoming access
  assign take = cpu_req_i && (state_q == ccm_pkg::DEV_IDLE);
  assign cpu_ready_o = (state_q == ccm_pkg::DEV_IDLE);

  always_comb begin
    hit = 1'b0;
    hit_way = '0;
    for (int w = 0; w < WAYS; w++) begin
      if (valid_q[idx_of(cpu_addr_i)][w] && (tag_mem[idx_of(cpu_addr_i)][w] == tag_of(cpu_addr_i))) begin
        hit = on_q;
        hit_way = WAY_W'(w);
      end
    end
  end

  assign dhit_ev = take && hit && !cpu_instr_i;
  assign ihit_ev = take && hit && cpu_instr_i;
  assign fill_done = (state_q == ccm_pkg::DEV_FILL) && mem_ack_i;
  assign fill_idx = idx_of(addr_q);
  assign fill_way = repl_q[idx_of(addr_q)];

  // access sequencer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= ccm_pkg::DEV_IDLE;
    end else begin
      unique case (state_q)
        ccm_pkg::DEV_IDLE: begin
          if (take) begin
            state_q <= hit ? ccm_pkg::DEV_HIT : ccm_pkg::DEV_FILL;
          end
        end
        ccm_pkg::DEV_HIT: state_q <= ccm_pkg::DEV_IDLE;
        ccm_pkg::DEV_FILL: begin
          if (mem_ack_i) begin
            state_q <= ccm_pkg::DEV_ANSWER;
          end
        end
        ccm_pkg::DEV_ANSWER: state_q <= ccm_pkg::DEV_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_q <= 32'h0;
      instr_q <= 1'b0;
    end else if (take) begin
      addr_q <= cpu_addr_i;
      instr_q <= cpu_instr_i;
    end
  end

  // answer to the processor: cached word on a hit, memory word otherwise
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0;
      ack_q <= 1'b0;
    end else begin
      ack_q <= (take && hit) || fill_done;
      if (take && hit) begin
        rdata_q <= data_mem[idx_of(cpu_addr_i)][hit_way];
      end else if (fill_done) begin
        rdata_q <= mem_rdata_i;
      end
    end
  end

  assign cpu_ack_o = ack_q;
  assign cpu_rdata_o = rdata_q;
  assign mem_req_o = (state_q == ccm_pkg::DEV_FILL);
  assign mem_addr_o = addr_q;

  // line storage, written only on allocation
  always_ff @(posedge ref_clk_i) begin
    if (fill_done && on_q) begin
      tag_mem[fill_idx][fill_way] <= tag_of(addr_q);
      data_mem[fill_idx][fill_way] <= mem_rdata_i;
    end
  end

  // valid bits: invalidation wins over a same-cycle allocation
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      valid_q <= '0;
    end else if (inv_all) begin
      valid_q <= '0;
    end else begin
      if (fill_done && on_q) begin
        valid_q[fill_idx][fill_way] <= 1'b1;
      end
      if (wr_maint1) begin
        valid_q[line_idx][line_way] <= 1'b0;
      end
    end
  end

  // replacement pointer per set
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      repl_q <= '0;
    end else if (wr_maint1) begin
      repl_q[line_idx] <= line_way;
    end else if (fill_done && on_q) begin
      repl_q[fill_idx] <= fill_way + WAY_W'(1);
    end
  end

  // enable and its status; status follows only between accesses
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
    end else if (wr_ctrl) begin
      en_q <= bus.reg_wdata[`CCM_BIT_EN];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      on_q <= 1'b0;
    end else if (state_q == ccm_pkg::DEV_IDLE && !cpu_req_i) begin
      on_q <= en_q;
    end
  end

  // monitor configuration
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_CYCLE;
      mrun_q <= 1'b0;
    end else begin
      if (wr_mcfg) begin
        mode_q <= bus.reg_wdata[`CCM_MODE_W-1:0];
      end
      if (wr_men) begin
        mrun_q <= bus.reg_wdata[`CCM_BIT_MRUN];
      end
    end
  end

  // monitor counter; clear has priority over counting
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count_q <= 32'h0;
    end else if (wr_mctrl && bus.reg_wdata[`CCM_BIT_MCLR]) begin
      count_q <= 32'h0;
    end else if (mrun_q) begin
      if ((mode_q == MODE_CYCLE) || (mode_q == MODE_DHIT && dhit_ev) || (mode_q == MODE_IHIT && ihit_ev)) begin
        count_q <= count_q + 32'h1;
      end
    end
  end

  // register read path, answered one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_ack_q <= 1'b0;
      reg_rdata_q <= '0;
    end else begin
      reg_ack_q <= bus.reg_rd || bus.reg_wr;
      reg_rdata_q <= '0;
      if (bus.reg_rd) begin
        if (reg_hit(bus.reg_addr, `CCM_OFF_CTRL)) begin
          reg_rdata_q[`CCM_BIT_EN] <= en_q;
        end
        if (reg_hit(bus.reg_addr, `CCM_OFF_SR)) begin
          reg_rdata_q[`CCM_BIT_ON] <= on_q;
        end
        if (reg_hit(bus.reg_addr, `CCM_OFF_MCFG)) begin
          reg_rdata_q[`CCM_MODE_W-1:0] <= mode_q;
        end
        if (reg_hit(bus.reg_addr, `CCM_OFF_MEN)) begin
          reg_rdata_q[`CCM_BIT_MRUN] <= mrun_q;
        end
        if (reg_hit(bus.reg_addr, `CCM_OFF_MSR)) begin
          reg_rdata_q <= count_q;
        end
      end
    end
  end

  assign bus.reg_ack = reg_ack_q;
  assign bus.reg_rdata = reg_rdata_q;
endmodule : ccm_cache
`default_nettype wire

// File: hdl/ccm_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccm_defs.svh"
module ccm_host #(
  parameter int IDX_W = 4,
  parameter int WAY_W = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  ccm_reg_if.host bus,
  input wire logic op_valid_i,
  input wire ccm_pkg::ccm_op_t op_i,
  input wire logic [IDX_W-1:0] op_index_i,
  input wire logic [WAY_W-1:0] op_way_i,
  input wire logic [`CCM_MODE_W-1:0] op_mode_i,
  output logic op_ready_o,
  output logic done_o,
  output logic [31:0] result_o
);
  ccm_pkg::ccm_host_state_t st_q;
  ccm_pkg::ccm_op_t op_q;
  logic [IDX_W-1:0] idx_q;
  logic [WAY_W-1:0] way_q;
  logic [`CCM_MODE_W-1:0] mode_q;
  logic [31:0] result_q;
  logic sr_on;

  assign sr_on = bus.reg_rdata[`CCM_BIT_ON];
  assign op_ready_o = (st_q == ccm_pkg::HS_IDLE);
  assign done_o = (st_q == ccm_pkg::HS_DONE);
  assign result_o = result_q;

  // command sequencer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q <= ccm_pkg::HS_IDLE;
    end else begin
      unique case (st_q)
        ccm_pkg::HS_IDLE: begin
          if (op_valid_i) begin
            unique case (op_i)
              ccm_pkg::OP_ENABLE: st_q <= ccm_pkg::HS_RD_SR;
              ccm_pkg::OP_DISABLE, ccm_pkg::OP_INV_LINE: st_q <= ccm_pkg::HS_WR_DIS;
              ccm_pkg::OP_INV_ALL: st_q <= ccm_pkg::HS_WR_INVALIDATE_EVERYTHING_BIT;
              ccm_pkg::OP_MON_START: st_q <= ccm_pkg::HS_WR_MCFG;
              ccm_pkg::OP_MON_CLEAR: st_q <= ccm_pkg::HS_WR_MCLR;
              ccm_pkg::OP_MON_READ: st_q <= ccm_pkg::HS_RD_MSR;
            endcase
          end
        end
        ccm_pkg::HS_WR_DIS: st_q <= ccm_pkg::HS_RD_SR;
        ccm_pkg::HS_RD_SR: st_q <= ccm_pkg::HS_WAIT_SR;
        ccm_pkg::HS_WAIT_SR: begin
          if (bus.reg_ack) begin
            if (sr_on) begin
              st_q <= (op_q == ccm_pkg::OP_ENABLE) ? ccm_pkg::HS_DONE : ccm_pkg::HS_RD_SR;
            end else if (op_q == ccm_pkg::OP_ENABLE) begin
              st_q <= ccm_pkg::HS_WR_EN;
            end else if (op_q == ccm_pkg::OP_INV_LINE) begin
              st_q <= ccm_pkg::HS_WR_LINE;
            end else begin
              st_q <= ccm_pkg::HS_DONE;
            end
          end
        end
        ccm_pkg::HS_WR_LINE: st_q <= ccm_pkg::HS_WR_EN;
        ccm_pkg::HS_WR_MCFG: st_q <= ccm_pkg::HS_WR_MEN;
        ccm_pkg::HS_WR_EN, ccm_pkg::HS_WR_INVALIDATE_EVERYTHING_BIT, ccm_pkg::HS_WR_MEN, ccm_pkg::HS_WR_MCLR: begin
          st_q <= ccm_pkg::HS_WAIT_WR;
        end
        ccm_pkg::HS_WAIT_WR: begin
          if (bus.reg_ack) begin
            st_q <= ccm_pkg::HS_DONE;
          end
        end
        ccm_pkg::HS_RD_MSR: st_q <= ccm_pkg::HS_WAIT_MSR;
        ccm_pkg::HS_WAIT_MSR: begin
          if (bus.reg_ack) begin
            st_q <= ccm_pkg::HS_DONE;
          end
        end
        ccm_pkg::HS_DONE: st_q <= ccm_pkg::HS_IDLE;
        default: st_q <= ccm_pkg::HS_IDLE;
      endcase
    end
  end

  // operands latched with the command
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      op_q <= ccm_pkg::OP_ENABLE;
      idx_q <= '0;
      way_q <= '0;
      mode_q <= '0;
    end else if (op_valid_i && st_q == ccm_pkg::HS_IDLE) begin
      op_q <= op_i;
      idx_q <= op_index_i;
      way_q <= op_way_i;
      mode_q <= op_mode_i;
    end
  end

  // read results
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      result_q <= 32'h0;
    end else if (bus.reg_ack && (st_q == ccm_pkg::HS_WAIT_MSR || st_q == ccm_pkg::HS_WAIT_SR)) begin
      result_q <= bus.reg_rdata;
    end
  end

  // bus strobes decoded from the sequencer state
  always_comb begin
    bus.reg_wr = 1'b0;
    bus.reg_rd = 1'b0;
    bus.reg_addr = '0;
    bus.reg_wdata = '0;
    unique case (st_q)
      ccm_pkg::HS_RD_SR: begin
        bus.reg_rd = 1'b1;
        bus.reg_addr = `CCM_OFF_SR;
      end
      ccm_pkg::HS_WR_DIS: begin
        bus.reg_wr = 1'b1;
        bus.reg_addr = `CCM_OFF_CTRL;
      end
      ccm_pkg::HS_WR_EN: begin
        bus.reg_wr = 1'b1;
        bus.reg_addr = `CCM_OFF_CTRL;
        bus.reg_wdata[`CCM_BIT_EN] = 1'b1;
      end
      ccm_pkg::HS_WR_LINE: begin
        bus.reg_wr = 1'b1;
        bus.reg_addr = `CCM_OFF_MAINT1;
        bus.reg_wdata[`CCM_LINE_IDX_LSB +: IDX_W] = idx_q;
        bus.reg_wdata[`CCM_LINE_WAY_LSB +: WAY_W] = way_q;
      end
      ccm_pkg::HS_WR_INVALIDATE_EVERYTHING_BIT: begin
        bus.reg_wr = 1'b1;
        bus.reg_addr = `CCM_OFF_MAINT0;
        bus.reg_wdata[`CCM_BIT_INVALIDATE_EVERYTHING_BIT] = 1'b1;
      end
      ccm_pkg::HS_WR_MCFG: begin
        bus.reg_wr = 1'b1;
        bus.reg_addr = `CCM_OFF_MCFG;
        bus.reg_wdata[`CCM_MODE_W-1:0] = mode_q;
      end
      ccm_pkg::HS_WR_MEN: begin
        bus.reg_wr = 1'b1;
        bus.reg_addr = `CCM_OFF_MEN;
        bus.reg_wdata[`CCM_BIT_MRUN] = 1'b1;
      end
      ccm_pkg::HS_WR_MCLR: begin
        bus.reg_wr = 1'b1;
        bus.reg_addr = `CCM_OFF_MCTRL;
        bus.reg_wdata[`CCM_BIT_MCLR] = 1'b1;
      end
      ccm_pkg::HS_RD_MSR: begin
        bus.reg_rd = 1'b1;
        bus.reg_addr = `CCM_OFF_MSR;
      end
      default: begin
        bus.reg_wr = 1'b0;
      end
    endcase
  end
endmodule : ccm_host
`default_nettype wire

// File: tb/ccm_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccm_defs.svh"
module ccm_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`CCM_ADDR_W-1:0] reg_addr,
  input wire logic [`CCM_DATA_W-1:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [`CCM_DATA_W-1:0] reg_rdata
);
  logic ctrl_q;
  logic sr_rd_q;
  logic sr_off_q;
  logic cfg_seen_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // shadow of the enable bit last written
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) ctrl_q <= 1'b0;
    else if (reg_wr && reg_addr == `CCM_OFF_CTRL) ctrl_q <= reg_wdata[`CCM_BIT_EN];
  end
  // last status read answered cache off, until the next enable write
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) sr_rd_q <= 1'b0;
    else sr_rd_q <= reg_rd && reg_addr == `CCM_OFF_SR;
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) sr_off_q <= 1'b0;
    else if (reg_wr && reg_addr == `CCM_OFF_CTRL && reg_wdata[`CCM_BIT_EN]) sr_off_q <= 1'b0;
    else if (sr_rd_q && reg_ack) sr_off_q <= !reg_rdata[`CCM_BIT_ON];
  end
  // mode register written since reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) cfg_seen_q <= 1'b0;
    else if (reg_wr && reg_addr == `CCM_OFF_MCFG) cfg_seen_q <= 1'b1;
  end
  ack_follows_strobe_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("register access not answered one cycle later");
  ack_has_cause_a: assert property (reg_ack |-> $past(reg_wr || reg_rd))
    else $error("answer without a preceding access");
  one_strobe_only_a: assert property (!(reg_wr && reg_rd))
    else $error("read and write strobes together");
  write_data_quiet_a: assert property (reg_wr |=> reg_rdata == '0)
    else $error("write answer carries read data");
  idle_bus_zero_a: assert property (!(reg_wr || reg_rd) |-> reg_addr == '0 && reg_wdata == '0)
    else $error("address or data not zero while bus idle");
  sr_upper_zero_a: assert property (reg_rd && reg_addr == `CCM_OFF_SR |=>
    reg_ack && reg_rdata[`CCM_DATA_W-1:`CCM_BIT_ON+1] == '0)
    else $error("status read returns unused bits set");
  check_before_enable_a: assert property (reg_wr && reg_addr == `CCM_OFF_CTRL && reg_wdata[`CCM_BIT_EN] |-> sr_off_q)
    else $error("enable written without confirming cache off");
  line_when_off_a: assert property (reg_wr && reg_addr == `CCM_OFF_MAINT1 |-> !ctrl_q)
    else $error("line invalidate while enable set");
  line_then_enable_a: assert property (reg_wr && reg_addr == `CCM_OFF_MAINT1 |-> ##[1:3]
    (reg_wr && reg_addr == `CCM_OFF_CTRL && reg_wdata[`CCM_BIT_EN]))
    else $error("cache not re-enabled after line invalidate");
  mode_before_run_a: assert property (reg_wr && reg_addr == `CCM_OFF_MEN && reg_wdata[`CCM_BIT_MRUN] |-> cfg_seen_q)
    else $error("monitor started before mode written");
endmodule : ccm_sva
`default_nettype wire

// File: tb/cache_controller_with_monitor_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccm_defs.svh"
module cache_controller_with_monitor_tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic op_valid_i = 1'b0;
  ccm_pkg::ccm_op_t op_i = ccm_pkg::OP_ENABLE;
  logic [3:0] op_index_i = 4'h0;
  logic [1:0] op_way_i = 2'h0;
  logic [1:0] op_mode_i = 2'h0;
  logic op_ready_o, done_o, cpu_ready_o, cpu_ack_o, mem_req_o;
  logic [31:0] result_o, cpu_rdata_o, mem_addr_o;
  logic cpu_req_i = 1'b0;
  logic cpu_instr_i = 1'b0;
  logic [31:0] cpu_addr_i = 32'h0;
  logic mem_ack_i = 1'b0;
  logic [31:0] mem_rdata_i = 32'h0;
  logic [31:0] r1;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int lat = 0;
  localparam logic [31:0] ADDR_A = 32'h0000_0105;
  localparam logic [31:0] ADDR_B = 32'h0000_0216;
  always #25 ref_clk_i = ~ref_clk_i;
  ccm_reg_if u_bus ();
  ccm_cache u_ccm_cache (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(u_bus.dev), .cpu_req_i(cpu_req_i),
    .cpu_addr_i(cpu_addr_i), .cpu_instr_i(cpu_instr_i), .cpu_ready_o(cpu_ready_o), .cpu_ack_o(cpu_ack_o),
    .cpu_rdata_o(cpu_rdata_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i));
  ccm_host u_ccm_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(u_bus.host), .op_valid_i(op_valid_i),
    .op_i(op_i), .op_index_i(op_index_i), .op_way_i(op_way_i), .op_mode_i(op_mode_i),
    .op_ready_o(op_ready_o), .done_o(done_o), .result_o(result_o));
  ccm_sva u_ccm_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr(u_bus.reg_wr), .reg_rd(u_bus.reg_rd),
    .reg_addr(u_bus.reg_addr), .reg_wdata(u_bus.reg_wdata), .reg_ack(u_bus.reg_ack),
    .reg_rdata(u_bus.reg_rdata));
  function automatic logic [31:0] memf(input logic [31:0] a);
    return a ^ 32'hc3a5_0f00;
  endfunction : memf
  // memory: latency from address bits, data inverted outside the answer cycle
  always @(negedge ref_clk_i) begin
    mem_ack_i <= 1'b0;
    mem_rdata_i <= ~memf(mem_addr_o);
    if (mem_req_o === 1'b1 && !mem_ack_i) begin
      if (lat >= int'(mem_addr_o[1:0])) begin
        mem_ack_i <= 1'b1;
        mem_rdata_i <= memf(mem_addr_o);
        lat <= 0;
      end else begin
        lat <= lat + 1;
      end
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic run_op(input ccm_pkg::ccm_op_t op, input logic [3:0] idx, input logic [1:0] mode);
    int k = 0;
    while (op_ready_o !== 1'b1 && k < 100) begin
      @(negedge ref_clk_i);
      k++;
    end
    op_i = op;
    op_index_i = idx;
    op_way_i = 2'h0;
    op_mode_i = mode;
    op_valid_i = 1'b1;
    @(negedge ref_clk_i);
    op_valid_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 200) begin
      @(negedge ref_clk_i);
      k++;
    end
    cmp("command done", 32'h1, {31'h0, done_o});
  endtask : run_op
  task automatic cpu_read(input logic [31:0] addr, input logic instr, input logic hit);
    int k = 0;
    while (cpu_ready_o !== 1'b1 && k < 100) begin
      @(negedge ref_clk_i);
      k++;
    end
    cpu_addr_i = addr;
    cpu_instr_i = instr;
    cpu_req_i = 1'b1;
    @(negedge ref_clk_i);
    cpu_req_i = 1'b0;
    k = 0;
    while (cpu_ack_o !== 1'b1 && k < 50) begin
      @(negedge ref_clk_i);
      k++;
    end
    cmp("cpu hit", {31'h0, hit}, {31'h0, k == 0});
    cmp("cpu data", memf(addr), cpu_rdata_o);
  endtask : cpu_read
  task automatic t_reset_state;
    run_op(ccm_pkg::OP_MON_READ, 4'h0, 2'h0);
    cmp("count after reset", 32'h0, result_o);
    cpu_read(ADDR_A, 1'b0, 1'b0);
    cpu_read(ADDR_A, 1'b0, 1'b0);
  endtask : t_reset_state
  task automatic t_enable;
    run_op(ccm_pkg::OP_ENABLE, 4'h0, 2'h0);
    cmp("status before enable", 32'h0, result_o);
    cpu_read(ADDR_A, 1'b0, 1'b0);
    cpu_read(ADDR_A, 1'b0, 1'b1);
    cpu_read(ADDR_B, 1'b1, 1'b0);
    cpu_read(ADDR_B, 1'b1, 1'b1);
    run_op(ccm_pkg::OP_ENABLE, 4'h0, 2'h0);
    cmp("status when on", 32'h1, result_o);
  endtask : t_enable
  task automatic t_maintenance;
    run_op(ccm_pkg::OP_INV_LINE, 4'h5, 2'h0);
    cpu_read(ADDR_A, 1'b0, 1'b0);
    cpu_read(ADDR_B, 1'b1, 1'b1);
    cpu_read(ADDR_A, 1'b0, 1'b1);
    run_op(ccm_pkg::OP_INV_ALL, 4'h0, 2'h0);
    cpu_read(ADDR_A, 1'b0, 1'b0);
    cpu_read(ADDR_B, 1'b1, 1'b0);
    run_op(ccm_pkg::OP_DISABLE, 4'h0, 2'h0);
    cmp("status after disable", 32'h0, result_o);
    cpu_read(ADDR_A, 1'b0, 1'b0);
    run_op(ccm_pkg::OP_ENABLE, 4'h0, 2'h0);
    cmp("status before re-enable", 32'h0, result_o);
    cpu_read(ADDR_A, 1'b0, 1'b1);
  endtask : t_maintenance
  task automatic t_monitor;
    for (int m = 1; m <= 2; m++) begin
      run_op(ccm_pkg::OP_MON_START, 4'h0, m[1:0]);
      run_op(ccm_pkg::OP_MON_CLEAR, 4'h0, 2'h0);
      cpu_read(ADDR_A, 1'b0, 1'b1);
      cpu_read(ADDR_A, 1'b0, 1'b1);
      cpu_read(ADDR_B, 1'b1, 1'b1);
      run_op(ccm_pkg::OP_MON_READ, 4'h0, 2'h0);
      cmp("hit count", (m[1:0] == `CCM_MODE_DHIT) ? 32'h2 : 32'h1, result_o);
    end
    run_op(ccm_pkg::OP_MON_CLEAR, 4'h0, 2'h0);
    run_op(ccm_pkg::OP_MON_READ, 4'h0, 2'h0);
    cmp("count after clear", 32'h0, result_o);
    run_op(ccm_pkg::OP_MON_START, 4'h0, `CCM_MODE_CYCLE);
    run_op(ccm_pkg::OP_MON_READ, 4'h0, 2'h0);
    r1 = result_o;
    run_op(ccm_pkg::OP_MON_READ, 4'h0, 2'h0);
    // two back-to-back status reads are four host cycles apart
    cmp("cycle count step", 32'h4, result_o - r1);
  endtask : t_monitor
  task automatic tally_and_finish;
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_reset_state();
    t_enable();
    t_maintenance();
    t_monitor();
    tally_and_finish();
  end
endmodule : cache_controller_with_monitor_tb
`default_nettype wire
